// [design/adcc_main_control.sv]
// Converter main control register and the logic it steers.
// Assumes operation and sample ticks are one-cycle pulses of clock_i.
`timescale 1ns/100ps
`default_nettype none
module adcc_main_control
    import adcc_pkg::*;
(
    input  wire logic       clock_i,           // 40 MHz system clock
    input  wire logic       resetn_i,          // Async reset, active low
    input  wire logic       ctrl_wr_i,         // Control register write strobe
    input  wire logic [7:0] ctrl_wdata_i,      // Write data
    output logic      [7:0] ctrl_rdata_o,      // Control register read value
    input  wire logic       op_tick_i,         // Operation clock tick
    input  wire logic       sample_tick_i,     // Sample rate clock tick
    input  wire logic       sample_rate_sel_i, // 0: 8 kHz, 1: 11 kHz
    input  wire logic       func_enabled_i,    // Any converter function on
    output logic            conv_clk_en_o,     // Gated converter clock enable
    output logic            conv_start_o,      // Conversion start pulse
    output logic            capture_o,         // Result capture pulse
    output logic            direct_mode_o,     // Interface bypassed
    output logic            cal_busy_o,        // Self-calibration running
    output logic            stop_strobe_o      // Converter power-down strobe
);

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    adcc_ctrl_type ctrl_ff;
    adcc_ctrl_type nxt_ctrl;

    // Register write with reserved bits forced low
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (ctrl_wr_i) begin
            nxt_ctrl = adcc_ctrl_type'(ctrl_wdata_i & ADCC_WRITE_MASK);
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_ff <= adcc_ctrl_type'(ADCC_CTRL_RESET);
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    assign ctrl_rdata_o  = ctrl_ff;
    assign direct_mode_o = ctrl_ff.direct_access_select;

    // ----------------------------------------------------------------
    // Clock gating and calibration
    // ----------------------------------------------------------------
    logic       pd;
    logic [9:0] cal_limit;
    logic [9:0] cal_count;
    logic       cal_done;

    assign pd            = ctrl_ff.converter_power_down;
    assign conv_clk_en_o = op_tick_i && !pd;

    // Calibration length select
    always_comb begin
        unique case ({ctrl_ff.extended_calibration, sample_rate_sel_i})
            2'b00: cal_limit = ADCC_CAL_SHORT_8K;
            2'b01: cal_limit = ADCC_CAL_SHORT_11;
            2'b10: cal_limit = ADCC_CAL_LONG_8K;
            2'b11: cal_limit = ADCC_CAL_LONG_11;
        endcase
    end

    // Calibration restarts whenever the converter is powered down
    adcc_tick_counter #(.W(10)) u_cal_cnt (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .clear_i  (pd),
        .step_i   (sample_tick_i),
        .wrap_i   (1'b0),
        .limit_i  (cal_limit),
        .count_o  (cal_count),
        .done_o   (cal_done)
    );

    assign cal_busy_o = !pd && !cal_done;

    // ----------------------------------------------------------------
    // Conversion phase and capture
    // ----------------------------------------------------------------
    logic [3:0] phase;
    logic [3:0] wait_off;
    logic       first_ff;
    logic       nxt_first;

    adcc_tick_counter #(.W(4)) u_phase_cnt (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .clear_i  (pd),
        .step_i   (op_tick_i),
        .wrap_i   (1'b1),
        .limit_i  (ADCC_CONV_LAST),
        .count_o  (phase),
        .done_o   ()
    );

    // Wait field decode
    always_comb begin
        unique case (ctrl_ff.wait_sel)
            2'b00: wait_off = ADCC_WAIT_0;
            2'b01: wait_off = ADCC_WAIT_2;
            2'b10: wait_off = ADCC_WAIT_4;
            2'b11: wait_off = ADCC_WAIT_4;
        endcase
    end

    // First full conversion seen since power-up
    always_comb begin
        nxt_first = first_ff;
        if (pd) begin
            nxt_first = 1'b0;
        end else if (op_tick_i && (phase == ADCC_CONV_LAST)) begin
            nxt_first = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            first_ff <= 1'b0;
        end else begin
            first_ff <= nxt_first;
        end
    end

    // Start every 16 ticks, capture wait_off ticks after completion
    assign conv_start_o = conv_clk_en_o && (phase == 4'h0);
    assign capture_o    = conv_clk_en_o && first_ff && (phase == wait_off)
                          && !ctrl_ff.direct_access_select && !cal_busy_o;

    // ----------------------------------------------------------------
    // Self power-off strobe
    // ----------------------------------------------------------------
    logic idle_req;
    logic idle_ff;
    logic stop_ff;
    logic nxt_stop;

    assign idle_req = ctrl_ff.self_power_off && !func_enabled_i && !pd;

    always_comb begin
        nxt_stop = idle_req && !idle_ff;
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            idle_ff <= 1'b0;
            stop_ff <= 1'b0;
        end else begin
            idle_ff <= idle_req;
            stop_ff <= nxt_stop;
        end
    end

    assign stop_strobe_o = stop_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_gate;
        @(posedge clock_i) disable iff (!resetn_i)
        pd |-> !conv_clk_en_o && !conv_start_o && !capture_o;
    endproperty
    a_gate: assert property (p_gate) else $error("clock not gated in power-down");

    property p_reserved;
        @(posedge clock_i) disable iff (!resetn_i)
        ctrl_wr_i |=> ctrl_rdata_o == {$past(ctrl_wdata_i[7:6]), 2'b00, $past(ctrl_wdata_i[3:0])};
    endproperty
    a_reserved: assert property (p_reserved) else $error("bad register write");

    sequence s_idle_rise;
        idle_req && !idle_ff;
    endsequence

    sequence s_one_pulse;
        stop_strobe_o ##1 !stop_strobe_o;
    endsequence

    property p_stop;
        @(posedge clock_i) disable iff (!resetn_i)
        s_idle_rise |=> s_one_pulse;
    endproperty
    a_stop: assert property (p_stop) else $error("stop strobe not one pulse");

    property p_capture;
        @(posedge clock_i) disable iff (!resetn_i)
        capture_o |-> first_ff && op_tick_i && !cal_busy_o
            && phase == (ctrl_ff.wait_sel == 2'b00 ? 4'h0 : (ctrl_ff.wait_sel == 2'b01 ? 4'h2 : 4'h4));
    endproperty
    a_capture: assert property (p_capture) else $error("capture at wrong phase");

    property p_direct;
        @(posedge clock_i) disable iff (!resetn_i)
        direct_mode_o |-> !capture_o;
    endproperty
    a_direct: assert property (p_direct) else $error("capture in direct mode");

    property p_cal_short;
        @(posedge clock_i) disable iff (!resetn_i)
        $fell(cal_busy_o) && !pd && !ctrl_ff.extended_calibration
            |-> cal_count == (sample_rate_sel_i ? 10'h080 : 10'h060);
    endproperty
    a_cal_short: assert property (p_cal_short) else $error("short calibration length");

    property p_cal_long;
        @(posedge clock_i) disable iff (!resetn_i)
        $fell(cal_busy_o) && !pd && ctrl_ff.extended_calibration
            |-> cal_count == (sample_rate_sel_i ? 10'h200 : 10'h180);
    endproperty
    a_cal_long: assert property (p_cal_long) else $error("long calibration length");

    property p_period;
        @(posedge clock_i) disable iff (!resetn_i)
        conv_start_o |-> phase == 4'h0 && !pd;
    endproperty
    a_period: assert property (p_period) else $error("start off phase zero");

    // Phase advances by one per gated tick, so 16 ticks per conversion
    property p_advance;
        @(posedge clock_i) disable iff (!resetn_i)
        conv_clk_en_o |=> phase == 4'($past(phase) + 4'h1);
    endproperty
    a_advance: assert property (p_advance) else $error("phase did not advance");

    property p_recal;
        @(posedge clock_i) disable iff (!resetn_i)
        $fell(pd) |-> cal_busy_o;
    endproperty
    a_recal: assert property (p_recal) else $error("no calibration after power-up");

endmodule
`default_nettype wire

// [design/adcc_tick_counter.sv]
// Step counter with limit, optional wrap, synchronous clear.
// Assumes step and clear come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module adcc_tick_counter #(
    parameter int W = 10
) (
    input  wire logic         clock_i,   // System clock
    input  wire logic         resetn_i,  // Async reset, active low
    input  wire logic         clear_i,   // Return count to zero
    input  wire logic         step_i,    // Count one tick
    input  wire logic         wrap_i,    // Wrap at limit instead of hold
    input  wire logic [W-1:0] limit_i,   // Terminal count
    output logic      [W-1:0] count_o,   // Current count
    output logic              done_o     // Count at or past limit
);

    logic [W-1:0] count_ff;
    logic [W-1:0] nxt_count;

    if (W < 2) begin : g_chk
        $error("adcc_tick_counter: W too small");
    end

    // Next count
    always_comb begin
        nxt_count = count_ff;
        if (clear_i) begin
            nxt_count = '0;
        end else if (step_i && (count_ff < limit_i)) begin
            nxt_count = count_ff + W'(1);
        end else if (step_i && wrap_i) begin
            nxt_count = '0;
        end
    end

    // Count register
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign count_o = count_ff;
    assign done_o  = (count_ff >= limit_i);

endmodule
`default_nettype wire

// [dv/adcc_core_model.sv]
// Behavioural converter core and tick source facing the control block.
// Assumes the bench enables the tick streams; counters run from reset.
`timescale 1ns/100ps
`default_nettype none
module adcc_core_model (
    input  wire logic        clock_i,       // System clock
    input  wire logic        resetn_i,      // Async reset, active low
    input  wire logic        op_run_i,      // Produce operation ticks
    input  wire logic        smp_run_i,     // Produce sample ticks
    input  wire logic        conv_clk_en_i, // Gated converter clock seen
    input  wire logic        conv_start_i,  // Conversion start seen
    input  wire logic        capture_i,     // Capture strobe seen
    input  wire logic        stop_i,        // Power-down strobe seen
    output logic             op_tick_o,     // Operation tick, every 2 cycles
    output logic             sample_tick_o, // Sample tick, every 4 cycles
    output logic      [15:0] smp_n_o,       // Sample ticks since run began
    output logic      [15:0] ens_o,         // Gated clock pulses seen
    output logic      [15:0] caps_o,        // Captures seen
    output logic      [7:0]  phase_o,       // Ticks from start to capture
    output logic      [7:0]  gap_o,         // Ticks between last two starts
    output logic      [7:0]  stops_o        // Stop strobes seen
);
    // ------------------------------------------------------------
    // Tick sources and converter bookkeeping
    // ------------------------------------------------------------
    logic [1:0] div;
    logic [7:0] since;
    // Ticks and counters
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {div, since, op_tick_o, sample_tick_o} <= '0;
            {smp_n_o, ens_o, caps_o, phase_o, gap_o, stops_o} <= '0;
        end else begin
            div <= div + 2'd1;
            op_tick_o <= op_run_i && div[0];
            sample_tick_o <= smp_run_i && (div == 2'd3);
            smp_n_o <= smp_run_i ? smp_n_o + 16'(sample_tick_o) : 16'h0000;
            ens_o <= ens_o + 16'(conv_clk_en_i); // Runs only while clocked
            if (conv_clk_en_i) begin
                since <= conv_start_i ? 8'h00 : since + 8'h01; // One conversion per 16 ticks
            end
            if (conv_clk_en_i && conv_start_i) begin
                gap_o <= since + 8'h01; // Start-to-start distance
            end
            if (capture_i) begin
                caps_o <= caps_o + 16'h0001;
                phase_o <= conv_start_i ? 8'h00 : since + 8'h01;
            end
            stops_o <= stops_o + 8'(stop_i);
        end
    end
endmodule
`default_nettype wire

// [dv/adcc_main_control_tb_top.sv]
// Self-checking bench for the converter main control block.
// Assumes the core model supplies the tick streams.
`timescale 1ns/100ps
`default_nettype none
module adcc_main_control_tb_top;
    // ------------------------------------------------------------
    // Clock, reset, stimulus and instances
    // ------------------------------------------------------------
    logic clock_i = 1'b0, resetn_i = 1'b0, ctrl_wr_i = 1'b0, rate_sel = 1'b0, func_en = 1'b0;
    logic op_run = 1'b0, smp_run = 1'b0, op_tick, smp_tick, clk_en, start, capt, direct, busy, stop;
    logic [7:0]  ctrl_wdata_i = 8'h00, rdata, phase, gap, stops;
    logic [15:0] smp_n, ens, caps;
    int bad_count = 0, checks = 0;
    adcc_main_control DUT (.clock_i(clock_i), .resetn_i(resetn_i), .ctrl_wr_i(ctrl_wr_i),
        .ctrl_wdata_i(ctrl_wdata_i), .ctrl_rdata_o(rdata), .op_tick_i(op_tick),
        .sample_tick_i(smp_tick), .sample_rate_sel_i(rate_sel), .func_enabled_i(func_en),
        .conv_clk_en_o(clk_en), .conv_start_o(start), .capture_o(capt),
        .direct_mode_o(direct), .cal_busy_o(busy), .stop_strobe_o(stop));
    adcc_core_model core (.clock_i(clock_i), .resetn_i(resetn_i), .op_run_i(op_run),
        .smp_run_i(smp_run), .conv_clk_en_i(clk_en), .conv_start_i(start), .capture_i(capt),
        .stop_i(stop), .op_tick_o(op_tick), .sample_tick_o(smp_tick), .smp_n_o(smp_n),
        .ens_o(ens), .caps_o(caps), .phase_o(phase), .gap_o(gap), .stops_o(stops));
    // 40 MHz clock
    initial begin
        forever #12.5 clock_i = ~clock_i;
    end
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // One register write, one-cycle strobe
    task automatic wr(input logic [7:0] d);
        @(posedge clock_i);
        #1 ctrl_wr_i = 1'b1;
        ctrl_wdata_i = d;
        cyc(1);
        ctrl_wr_i = 1'b0;
    endtask
    task automatic t_fields();
        chk(rdata, 16'h0080);
        chk(rdata[0], 1'b0);
        op_run = 1'b1;
        cyc(40);
        chk(ens, 16'h0000);
        wr(8'hFF);
        chk(rdata, 16'h00CF);
        chk(direct, 1'b1);
        wr(8'h80);
        chk({direct, busy}, 2'b00);
        $display("test fields done");
    endtask
    // Count sample ticks until calibration ends
    task automatic t_cal(input logic [7:0] ctl, input logic rate, input logic [15:0] exp);
        int n;
        n = 0;
        wr(8'h80);
        rate_sel = rate;
        wr(ctl);
        chk(busy, 1'b1);
        smp_run = 1'b1;
        while (busy !== 1'b0 && n < 3000) begin
            cyc(1);
            n++;
        end
        smp_run = 1'b0;
        chk(smp_n, exp);
        $display("test calibration done");
    endtask
    // Capture distance for every wait code
    task automatic t_capture();
        logic [15:0] c0;
        logic [7:0] want [4];
        want = '{8'd16, 8'd18, 8'd20, 8'd20};
        for (int w = 0; w < 4; w++) begin
            wr({4'h0, 2'(w), 2'b01});
            cyc(80);
            c0 = caps;
            cyc(80);
            chk(caps > c0, 1'b1);
            chk(phase + 8'd16, want[w]);
            chk(gap, 16'h0010);
        end
        wr(8'h40);
        cyc(80);
        c0 = caps;
        cyc(80);
        chk(caps, c0);
        wr(8'h80);
        c0 = ens;
        cyc(40);
        chk(ens, c0);
        $display("test capture done");
    endtask
    task automatic t_stop();
        logic [7:0] s0;
        func_en = 1'b1;
        wr(8'h02);
        s0 = stops;
        cyc(10);
        chk(stops, s0);
        func_en = 1'b0;
        cyc(6);
        chk(stops, s0 + 8'h01);
        $display("test stop done");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        cyc(8);
        resetn_i = 1'b1;
        t_fields();
        t_cal(8'h00, 1'b0, 16'd96);
        t_cal(8'h00, 1'b1, 16'd128);
        t_cal(8'h01, 1'b0, 16'd384);
        t_cal(8'h01, 1'b1, 16'd512);
        t_capture();
        t_stop();
        stop_test();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire

// [pkg/adcc_pkg.sv]
// Constants, types and field layout of the converter main control block.
// Assumes a single 40 MHz clock and same-domain tick inputs.
`default_nettype none
package adcc_pkg;

    // ----------------------------------------------------------------
    // Register map and fields
    // ----------------------------------------------------------------
    localparam logic [11:0] ADCC_CTRL_OFFSET  = 12'h000;
    localparam logic [7:0]  ADCC_CTRL_RESET   = 8'h80;
    localparam int          ADCC_PD_BIT       = 7;
    localparam int          ADCC_DIRECT_BIT   = 6;
    localparam int          ADCC_WAIT_LSB     = 2;
    localparam int          ADCC_SOP_BIT      = 1;
    localparam int          ADCC_EXTCAL_BIT   = 0;
    localparam logic [7:0]  ADCC_WRITE_MASK   = 8'hCF;

    // ----------------------------------------------------------------
    // Timing counts
    // ----------------------------------------------------------------
    localparam logic [3:0]  ADCC_CONV_LAST    = 4'hF;    // 16 ticks per conversion
    localparam logic [3:0]  ADCC_WAIT_0       = 4'h0;    // Capture after 16
    localparam logic [3:0]  ADCC_WAIT_2       = 4'h2;    // Capture after 18
    localparam logic [3:0]  ADCC_WAIT_4       = 4'h4;    // Capture after 20
    localparam logic [9:0]  ADCC_CAL_SHORT_8K = 10'h060; // 96
    localparam logic [9:0]  ADCC_CAL_SHORT_11 = 10'h080; // 128
    localparam logic [9:0]  ADCC_CAL_LONG_8K  = 10'h180; // 384
    localparam logic [9:0]  ADCC_CAL_LONG_11  = 10'h200; // 512

    // ----------------------------------------------------------------
    // Control register image
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       converter_power_down;
        logic       direct_access_select;
        logic [1:0] reserved;
        logic [1:0] wait_sel;
        logic       self_power_off;
        logic       extended_calibration;
    } adcc_ctrl_type;

endpackage
`default_nettype wire
